// File: hw/sbm_defs.svh
// constants of the bus matrix and apb bridge
// assumes a single 50 MHz core clock and 32-bit masters
`ifndef SBM_DEFS_SVH
`define SBM_DEFS_SVH
`define SBM_NM 4
`define SBM_NS 4
`define SBM_S_FLASH 2'h0
`define SBM_S_SRAM 2'h1
`define SBM_S_APB 2'h2
`define SBM_S_EXT 2'h3
`define SBM_RGN_MSB 31
`define SBM_RGN_LSB 29
`define SBM_RGN_FLASH 3'h0
`define SBM_RGN_SRAM 3'h1
`define SBM_RGN_APB 3'h2
`define SBM_RGN_EXT 3'h3
`define SBM_SZ_BYTE 2'h0
`define SBM_SZ_HALF 2'h1
`define SBM_SZ_WORD 2'h2
`define SBM_CLK_HZ 50000000
`define SBM_APB_MAX_HZ 24000000
`define SBM_APB_DIV ((`SBM_CLK_HZ + `SBM_APB_MAX_HZ - 1) / `SBM_APB_MAX_HZ)
`define SBM_CLK_EN_RST 32'h0000_0003
`define SBM_FLD_NUM 9
`endif

// File: hw/sbm_pkg.sv
// types shared by the bus matrix and the field cells
// assumes sbm_defs.svh for numeric constants
package sbm_pkg;
   typedef enum logic [3:0] {
      SBM_FLD_RW = 4'h0,
      SBM_FLD_RO = 4'h1,
      SBM_FLD_WO = 4'h2,
      SBM_FLD_C1 = 4'h3,
      SBM_FLD_C0 = 4'h4,
      SBM_FLD_CR = 4'h5,
      SBM_FLD_SET = 4'h6,
      SBM_FLD_TRIG = 4'h7,
      SBM_FLD_TOG = 4'h8
   } sbm_field_kind_t;
   typedef enum logic [1:0] {
      SBM_APB_IDLE = 2'h0,
      SBM_APB_SETUP = 2'h1,
      SBM_APB_ACCESS = 2'h2
   } sbm_apb_state_t;
endpackage : sbm_pkg

// File: hw/sbm_matrix.sv
// round-robin bus matrix with apb bridge and register field cells
// assumes masters hold valid and request fields until done, all on core_clk_in
`timescale 1ns/1ns
`include "sbm_defs.svh"

// one register bit with a selectable software access behaviour
module sbm_field import sbm_pkg::*; #(
   parameter sbm_field_kind_t KIND = SBM_FLD_RW,
   parameter logic RST = 1'b0
) (
   input wire logic core_clk_in,
   input wire logic rstn_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic wbit_in,
   input wire logic hw_set_in,
   output logic rbit_out,
   output logic trig_out
);
   logic val_q;
   logic val_d;
   always_comb begin
      case (KIND)
         SBM_FLD_RW: val_d = wr_in ? wbit_in : val_q; // [R1]
         SBM_FLD_RO: val_d = hw_set_in; // [R2]
         SBM_FLD_WO: val_d = wr_in ? wbit_in : val_q; // [R3]
         SBM_FLD_C1: val_d = hw_set_in | (val_q & ~(wr_in & wbit_in)); // [R4]
         SBM_FLD_C0: val_d = hw_set_in | (val_q & ~(wr_in & ~wbit_in)); // [R5]
         SBM_FLD_CR: val_d = hw_set_in | (val_q & ~rd_in); // [R6]
         SBM_FLD_SET: val_d = hw_set_in | val_q | (wr_in & wbit_in); // [R7]
         SBM_FLD_TRIG: val_d = hw_set_in | val_q; // [R8]
         SBM_FLD_TOG: val_d = val_q ^ (wr_in & wbit_in); // [R9]
         default: val_d = val_q;
      endcase
   end
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         val_q <= RST;
      end else begin
         val_q <= val_d;
      end
   end
   always_comb begin
      rbit_out = (KIND == SBM_FLD_WO) ? RST : val_q; // [R3]
      trig_out = (KIND == SBM_FLD_TRIG) & wr_in; // [R8]
   end
endmodule : sbm_field
// Summary of operation
// [R1] rw field stores writes, reads back value
// [R2] read-only field shows hardware value, ignores writes
// [R3] write-only field reads back its reset value
// [R4] writing one clears; zero leaves alone
// [R5] writing zero clears; one leaves alone
// [R6] read returns value then clears it
// [R7] writing one sets; zero leaves alone
// [R8] any write pulses trigger, value unchanged
// [R9] writing one toggles; zero leaves alone
// [R10] software keeps reserved bits at reset value
// [R11] round-robin arbitration among simultaneous masters
// [R12] small build: three masters, three slaves
// [R13] large build adds second dma, external memory
// [R14] narrow apb writes replicated to 32 bits
// [R15] reset gates peripheral clocks except sram, flash
// [R16] software enables clock before using peripheral
// [R17] apb synchronous, paced at most 24 MHz
// [R18] ahb peripherals reachable by cpu and dma
// [R19] little endian byte lanes
// [R20] top three address bits pick region
// [R21] byte, half-word and word transfer sizes
// [R22] unassigned regions decoded as reserved
// [R23] reserved access ends with error response
// [R24] pointer moves past last granted master
module sbm_matrix import sbm_pkg::*; #(
   parameter bit LARGE_CFG = 1'b1
) (
   input wire logic core_clk_in,
   input wire logic rstn_in,
   input wire logic [`SBM_NM-1:0] m_valid_in,
   input wire logic [`SBM_NM-1:0][31:0] m_addr_in,
   input wire logic [`SBM_NM-1:0] m_write_in,
   input wire logic [`SBM_NM-1:0][1:0] m_size_in,
   input wire logic [`SBM_NM-1:0][31:0] m_wdata_in,
   output logic [`SBM_NM-1:0] m_done_out,
   output logic [`SBM_NM-1:0] m_err_out,
   output logic [`SBM_NM-1:0][31:0] m_rdata_out,
   output logic [`SBM_NS-1:0] mem_valid_out,
   output logic [`SBM_NS-1:0][31:0] mem_addr_out,
   output logic [`SBM_NS-1:0] mem_write_out,
   output logic [`SBM_NS-1:0][3:0] mem_strb_out,
   output logic [`SBM_NS-1:0][31:0] mem_wdata_out,
   input wire logic [`SBM_NS-1:0] mem_ready_in,
   input wire logic [`SBM_NS-1:0][31:0] mem_rdata_in,
   output logic apb_psel_out,
   output logic apb_penable_out,
   output logic [31:0] apb_paddr_out,
   output logic apb_pwrite_out,
   output logic [31:0] apb_pwdata_out,
   input wire logic apb_pready_in,
   input wire logic [31:0] apb_prdata_in,
   input wire logic apb_pslverr_in,
   input wire logic fld_wr_in,
   input wire logic fld_rd_in,
   input wire logic [`SBM_FLD_NUM-1:0] fld_wdata_in,
   input wire logic [`SBM_FLD_NUM-1:0] fld_hw_set_in,
   output logic [`SBM_FLD_NUM-1:0] fld_rdata_out,
   output logic [`SBM_FLD_NUM-1:0] fld_trig_out,
   input wire logic clk_en_wr_in,
   input wire logic [31:0] clk_en_wdata_in,
   output logic [31:0] periph_clk_en_out
);
   localparam int NM = `SBM_NM;
   localparam int NS = `SBM_NS;
   localparam logic [1:0] APB_DIV_M1 = 2'(`SBM_APB_DIV - 1);
   logic [NM-1:0][1:0] tgt;
   logic [NM-1:0] rsv;
   logic [NM-1:0] live;
   logic [NS-1:0][NM-1:0] req;
   logic [NS-1:0] grant;
   logic [NS-1:0][1:0] pick;
   logic [NS-1:0] comp;
   logic [NS-1:0][31:0] comp_rdata;
   logic [NM-1:0] active_q;
   logic [NM-1:0] done_q;
   logic [NM-1:0] err_q;
   logic [NM-1:0][31:0] rdata_q;
   logic [NS-1:0] busy_q;
   logic [NS-1:0][1:0] last_q;
   logic [NS-1:0] valid_q;
   logic [NS-1:0][31:0] addr_q;
   logic [NS-1:0] write_q;
   logic [NS-1:0][3:0] strb_q;
   logic [NS-1:0][31:0] wdata_q;
   sbm_apb_state_t apb_state_q;
   logic apb_psel_q;
   logic apb_penable_q;
   logic [1:0] div_q;
   logic tick;
   logic [`SBM_FLD_NUM-1:0] fld_rbit;
   logic [`SBM_FLD_NUM-1:0] fld_trig;
   logic [`SBM_FLD_NUM-1:0] fld_rdata_q;
   logic [`SBM_FLD_NUM-1:0] fld_trig_q;
   logic [31:0] clk_en_q;
   // next master after last, wrapping, last itself lowest
   function automatic logic [1:0] rr_pick(input logic [3:0] r, input logic [1:0] last);
      logic [1:0] idx;
      rr_pick = last;
      for (int k = 4; k >= 1; k--) begin
         idx = last + 2'(k);
         if (r[idx]) begin
            rr_pick = idx;
         end
      end
   endfunction : rr_pick
   // byte lanes from size and low address bits, lane 0 lowest
   function automatic logic [3:0] lane_strb(input logic [1:0] sz, input logic [1:0] a);
      case (sz)
         `SBM_SZ_BYTE: lane_strb = 4'h1 << a; // [R19] [R21]
         `SBM_SZ_HALF: lane_strb = a[1] ? 4'hc : 4'h3; // [R21]
         default: lane_strb = 4'hf; // [R21]
      endcase
   endfunction : lane_strb
   // narrow data copied onto every lane of the word
   function automatic logic [31:0] lane_rep(input logic [31:0] d, input logic [1:0] sz,
                                            input logic [1:0] a);
      case (sz)
         `SBM_SZ_BYTE: lane_rep = {4{d[{a, 3'h0} +: 8]}}; // [R14]
         `SBM_SZ_HALF: lane_rep = {2{d[{a[1], 4'h0} +: 16]}}; // [R14]
         default: lane_rep = d;
      endcase
   endfunction : lane_rep
   // address decode, master eligibility
   always_comb begin
      for (int m = 0; m < NM; m++) begin
         rsv[m] = 1'b0;
         case (m_addr_in[m][`SBM_RGN_MSB:`SBM_RGN_LSB]) // [R20]
            `SBM_RGN_FLASH: tgt[m] = `SBM_S_FLASH;
            `SBM_RGN_SRAM: tgt[m] = `SBM_S_SRAM;
            `SBM_RGN_APB: tgt[m] = `SBM_S_APB; // [R18]
            `SBM_RGN_EXT: begin
               tgt[m] = `SBM_S_EXT;
               rsv[m] = ~LARGE_CFG; // [R12] [R13]
            end
            default: begin
               tgt[m] = `SBM_S_FLASH;
               rsv[m] = 1'b1; // [R22]
            end
         endcase
         live[m] = m_valid_in[m] & ~active_q[m] & ~done_q[m] & ((m != NM - 1) | LARGE_CFG); // [R12] [R13]
      end
   end
   // per-slave request vectors and winners
   always_comb begin
      for (int s = 0; s < NS; s++) begin
         for (int m = 0; m < NM; m++) begin
            req[s][m] = live[m] & ~rsv[m] & (tgt[m] == 2'(s));
         end
         pick[s] = rr_pick(req[s], last_q[s]); // [R11] [R24]
         grant[s] = ~busy_q[s] & (|req[s]);
      end
   end
   // completion of the transfer in flight at each slave
   always_comb begin
      for (int s = 0; s < NS; s++) begin
         if (s == int'(`SBM_S_APB)) begin
            comp[s] = (apb_state_q == SBM_APB_ACCESS) & tick & apb_pready_in;
            comp_rdata[s] = apb_prdata_in;
         end else begin
            comp[s] = valid_q[s] & mem_ready_in[s];
            comp_rdata[s] = mem_rdata_in[s];
         end
      end
   end
   // slave side request registers and arbitration pointer
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         busy_q <= '0;
         last_q <= '0;
         valid_q <= '0;
         addr_q <= '0;
         write_q <= '0;
         strb_q <= '0;
         wdata_q <= '0;
      end else begin
         for (int s = 0; s < NS; s++) begin
            if (grant[s]) begin
               busy_q[s] <= 1'b1;
               last_q[s] <= pick[s]; // [R24]
               valid_q[s] <= (s != int'(`SBM_S_APB));
               addr_q[s] <= m_addr_in[pick[s]];
               write_q[s] <= m_write_in[pick[s]];
               strb_q[s] <= lane_strb(m_size_in[pick[s]], m_addr_in[pick[s]][1:0]);
               wdata_q[s] <= lane_rep(m_wdata_in[pick[s]], m_size_in[pick[s]],
                                      m_addr_in[pick[s]][1:0]);
            end else if (comp[s]) begin
               busy_q[s] <= 1'b0;
               valid_q[s] <= 1'b0;
            end
         end
      end
   end
   // apb pacing enable, never faster than the apb limit
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         div_q <= '0;
      end else if (div_q == APB_DIV_M1) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 2'h1;
      end
   end
   assign tick = (div_q == APB_DIV_M1); // [R17]
   // apb setup and access phases
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         apb_state_q <= SBM_APB_IDLE;
         apb_psel_q <= 1'b0;
         apb_penable_q <= 1'b0;
      end else begin
         case (apb_state_q)
            SBM_APB_IDLE: begin
               if (grant[`SBM_S_APB]) begin
                  apb_state_q <= SBM_APB_SETUP;
                  apb_psel_q <= 1'b1;
               end
            end
            SBM_APB_SETUP: begin
               if (tick) begin // [R17]
                  apb_state_q <= SBM_APB_ACCESS;
                  apb_penable_q <= 1'b1;
               end
            end
            SBM_APB_ACCESS: begin
               if (comp[`SBM_S_APB]) begin
                  apb_state_q <= SBM_APB_IDLE;
                  apb_psel_q <= 1'b0;
                  apb_penable_q <= 1'b0;
               end
            end
            default: begin
               apb_state_q <= SBM_APB_IDLE;
               apb_psel_q <= 1'b0;
               apb_penable_q <= 1'b0;
            end
         endcase
      end
   end
   // master answers: done pulse, error flag, read word
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         done_q <= '0;
         err_q <= '0;
         rdata_q <= '0;
         active_q <= '0;
      end else begin
         for (int m = 0; m < NM; m++) begin
            done_q[m] <= 1'b0;
            err_q[m] <= 1'b0;
            if (live[m] & rsv[m]) begin
               done_q[m] <= 1'b1; // [R23]
               err_q[m] <= 1'b1; // [R23]
               rdata_q[m] <= '0;
            end
            for (int s = 0; s < NS; s++) begin
               if (grant[s] & (pick[s] == 2'(m))) begin
                  active_q[m] <= 1'b1;
               end
               if (comp[s] & (last_q[s] == 2'(m))) begin
                  active_q[m] <= 1'b0;
                  done_q[m] <= 1'b1;
                  err_q[m] <= (s == int'(`SBM_S_APB)) & apb_pslverr_in;
                  rdata_q[m] <= comp_rdata[s];
               end
            end
         end
      end
   end
   // one cell of each access kind
   for (genvar i = 0; i < `SBM_FLD_NUM; i++) begin : g_fld
      sbm_field #(
         .KIND(sbm_field_kind_t'(i)),
         .RST(1'b0)
      ) u_fld ( // [R1] [R2] [R3] [R4] [R5] [R7] [R9]
         .core_clk_in(core_clk_in),
         .rstn_in(rstn_in),
         .wr_in(fld_wr_in),
         .rd_in(fld_rd_in),
         .wbit_in(fld_wdata_in[i]),
         .hw_set_in(fld_hw_set_in[i]),
         .rbit_out(fld_rbit[i]),
         .trig_out(fld_trig[i])
      );
   end
   // read capture and trigger pulses
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         fld_rdata_q <= '0;
         fld_trig_q <= '0;
      end else begin
         fld_trig_q <= fld_trig; // [R8]
         if (fld_rd_in) begin
            fld_rdata_q <= fld_rbit; // [R6]
         end
      end
   end
   // peripheral clock gates
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         clk_en_q <= `SBM_CLK_EN_RST; // [R15]
      end else if (clk_en_wr_in) begin
         clk_en_q <= clk_en_wdata_in;
      end
   end
   assign m_done_out = done_q;
   assign m_err_out = err_q;
   assign m_rdata_out = rdata_q;
   assign mem_valid_out = valid_q;
   assign mem_addr_out = addr_q;
   assign mem_write_out = write_q;
   assign mem_strb_out = strb_q;
   assign mem_wdata_out = wdata_q;
   assign apb_psel_out = apb_psel_q;
   assign apb_penable_out = apb_penable_q;
   assign apb_paddr_out = addr_q[`SBM_S_APB];
   assign apb_pwrite_out = write_q[`SBM_S_APB];
   assign apb_pwdata_out = wdata_q[`SBM_S_APB]; // [R14]
   assign fld_rdata_out = fld_rdata_q;
   assign fld_trig_out = fld_trig_q;
   assign periph_clk_en_out = clk_en_q;
endmodule : sbm_matrix

// File: bench/sbm_matrix_checker.sv
// checker of the bus matrix, field cells and apb pacing
// assumes the ports of sbm_matrix and the constants of sbm_defs.svh
`timescale 1ns/1ns
`include "sbm_defs.svh"
module sbm_matrix_checker import sbm_pkg::*; (
   input wire logic core_clk_in,
   input wire logic rstn_in,
   input wire logic [`SBM_NM-1:0] m_valid_in,
   input wire logic [`SBM_NM-1:0][31:0] m_addr_in,
   input wire logic [`SBM_NM-1:0][1:0] m_size_in,
   input wire logic [`SBM_NM-1:0][31:0] m_wdata_in,
   input wire logic [`SBM_NM-1:0] m_done_out,
   input wire logic [`SBM_NM-1:0] m_err_out,
   input wire logic [`SBM_NS-1:0] mem_valid_out,
   input wire logic [`SBM_NS-1:0][31:0] mem_addr_out,
   input wire logic [`SBM_NS-1:0] mem_ready_in,
   input wire logic apb_psel_out,
   input wire logic apb_penable_out,
   input wire logic apb_pwrite_out,
   input wire logic [31:0] apb_pwdata_out,
   input wire logic fld_wr_in,
   input wire logic fld_rd_in,
   input wire logic [`SBM_FLD_NUM-1:0] fld_hw_set_in,
   input wire logic [`SBM_FLD_NUM-1:0] fld_rdata_out,
   input wire logic [`SBM_FLD_NUM-1:0] fld_trig_out,
   input wire logic [31:0] periph_clk_en_out
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rstn_in);
   a_reserved_err: assert property (
      m_valid_in[0] && m_addr_in[0][31:29] >= 3'h4 && !m_done_out[0]
      |=> m_done_out[0] && m_err_out[0]) else $error("reserved access not refused");
   a_trig_on_wr: assert property (fld_wr_in |=> fld_trig_out[7])
      else $error("write gave no trigger pulse");
   a_trig_only_wr: assert property (fld_trig_out[7] |-> $past(fld_wr_in))
      else $error("trigger pulse without write");
   a_wo_reads_zero: assert property (fld_rd_in |=> !fld_rdata_out[2])
      else $error("write-only bit read nonzero");
   a_read_clears: assert property (
      (fld_rd_in && !fld_hw_set_in[5]) ##1 (!fld_rd_in && !fld_hw_set_in[5]) ##1 fld_rd_in
      |=> !fld_rdata_out[5]) else $error("clear-on-read bit not cleared");
   a_clk_en_reset: assert property (
      $rose(rstn_in) |-> periph_clk_en_out == `SBM_CLK_EN_RST)
      else $error("clock gates wrong after reset");
   a_apb_enable_sel: assert property (apb_penable_out |-> apb_psel_out)
      else $error("penable without psel");
   a_apb_setup_first: assert property ($rose(apb_psel_out) |-> !apb_penable_out)
      else $error("no setup phase");
   a_apb_tick_pace: assert property (
      apb_psel_out && !apb_penable_out |-> ##[1:3] apb_penable_out)
      else $error("access phase late");
   a_byte_repl: assert property (
      apb_psel_out && apb_pwrite_out && m_valid_in[0] && m_size_in[0] == `SBM_SZ_BYTE
      |-> apb_pwdata_out == {4{m_wdata_in[0][8*m_addr_in[0][1:0] +: 8]}})
      else $error("narrow apb data not replicated");
   a_mem_hold: assert property (
      mem_valid_out[1] && !mem_ready_in[1] |=> mem_valid_out[1] && $stable(mem_addr_out[1]))
      else $error("memory request dropped");
   c_reserved: cover property (m_done_out[0] && m_err_out[0]);
   c_trigger: cover property (fld_trig_out[7]);
   c_apb_write: cover property (apb_penable_out && apb_pwrite_out);
endmodule : sbm_matrix_checker

bind sbm_matrix sbm_matrix_checker CHK (.core_clk_in, .rstn_in, .m_valid_in, .m_addr_in,
   .m_size_in, .m_wdata_in, .m_done_out, .m_err_out, .mem_valid_out, .mem_addr_out,
   .mem_ready_in, .apb_psel_out, .apb_penable_out, .apb_pwrite_out, .apb_pwdata_out,
   .fld_wr_in, .fld_rd_in, .fld_hw_set_in, .fld_rdata_out, .fld_trig_out,
   .periph_clk_en_out);

// File: bench/sbm_slave_model.sv
// slave side model: three memories and one apb register
// assumes the slave ports of sbm_matrix; slow_in sets wait cycles
`timescale 1ns/1ns
`include "sbm_defs.svh"
module sbm_slave_model import sbm_pkg::*; (
   input wire logic core_clk_in,
   input wire logic [`SBM_NS-1:0] mem_valid_out,
   input wire logic [`SBM_NS-1:0][31:0] mem_addr_out,
   input wire logic [`SBM_NS-1:0] mem_write_out,
   input wire logic [`SBM_NS-1:0][3:0] mem_strb_out,
   input wire logic [`SBM_NS-1:0][31:0] mem_wdata_out,
   output logic [`SBM_NS-1:0] mem_ready_in,
   output logic [`SBM_NS-1:0][31:0] mem_rdata_in,
   input wire logic apb_psel_out,
   input wire logic apb_penable_out,
   input wire logic [31:0] apb_paddr_out,
   input wire logic apb_pwrite_out,
   input wire logic [31:0] apb_pwdata_out,
   output logic apb_pready_in,
   output logic [31:0] apb_prdata_in,
   output logic apb_pslverr_in,
   input wire logic [1:0] slow_in
);
   logic [31:0] mem_q [4][16] = '{default: '0};
   logic [31:0] apb_q = '0;
   logic [2:0] wait_q [4] = '{default: '0};
   logic [2:0] await_q = '0;
   // data lines flip while not answering
   always_comb begin
      for (int s = 0; s < 4; s++) begin
         mem_ready_in[s] = mem_valid_out[s] && s != 2 && wait_q[s] >= {1'b0, slow_in};
         mem_rdata_in[s] = mem_q[s][mem_addr_out[s][5:2]] ^ {32{!mem_ready_in[s]}};
      end
      apb_pready_in = apb_psel_out && apb_penable_out && await_q >= {1'b0, slow_in};
      apb_pslverr_in = apb_pready_in && apb_paddr_out[7:0] == 8'hfc;
      apb_prdata_in = apb_q ^ {32{!apb_pready_in}};
   end
   always @(posedge core_clk_in) begin
      for (int s = 0; s < 4; s++) begin
         wait_q[s] <= (mem_valid_out[s] && !mem_ready_in[s]) ? wait_q[s] + 3'h1 : 3'h0;
         for (int b = 0; b < 4; b++)
            if (mem_ready_in[s] && mem_write_out[s] && mem_strb_out[s][b])
               mem_q[s][mem_addr_out[s][5:2]][8*b +: 8] <= mem_wdata_out[s][8*b +: 8];
      end
      // ready held until the bridge ends the access phase
      await_q <= !apb_penable_out ? 3'h0 : apb_pready_in ? await_q : await_q + 3'h1;
      if (apb_pready_in && apb_pwrite_out)
         apb_q <= apb_pwdata_out;
   end
endmodule : sbm_slave_model

// File: bench/system_bus_matrix_apb_bridge_tb_top.sv
// testbench of the bus matrix with slave model and field register
// assumes sbm_matrix with four masters and the slave model
`timescale 1ns/1ns
`include "sbm_defs.svh"
module system_bus_matrix_apb_bridge_tb_top import sbm_pkg::*;;
   localparam logic [1:0] B = `SBM_SZ_BYTE, H = `SBM_SZ_HALF, W = `SBM_SZ_WORD;
   logic core_clk_in = 1'b0, rstn_in = 1'b0, fld_wr_in = 1'b0, fld_rd_in = 1'b0;
   logic clk_en_wr_in = 1'b0, apb_psel_out, apb_penable_out, apb_pwrite_out;
   logic apb_pready_in, apb_pslverr_in;
   logic [`SBM_NM-1:0] m_valid_in = '0, m_write_in = '0, m_done_out, m_err_out;
   logic [`SBM_NM-1:0][31:0] m_addr_in = '0, m_wdata_in = '0, m_rdata_out;
   logic [`SBM_NM-1:0][1:0] m_size_in = '0;
   logic [`SBM_NS-1:0] mem_valid_out, mem_write_out, mem_ready_in;
   logic [`SBM_NS-1:0][31:0] mem_addr_out, mem_wdata_out, mem_rdata_in;
   logic [`SBM_NS-1:0][3:0] mem_strb_out;
   logic [31:0] apb_paddr_out, apb_pwdata_out, apb_prdata_in, periph_clk_en_out;
   logic [31:0] clk_en_wdata_in = '0;
   logic [`SBM_FLD_NUM-1:0] fld_wdata_in = '0, fld_hw_set_in = '0, fld_rdata_out, fld_trig_out;
   logic [1:0] slow = 2'h0;
   int failures = 0, checked = 0, cyc = 0;
   int order[$];
   sbm_matrix #(.LARGE_CFG(1'b1)) DUT (.core_clk_in, .rstn_in, .m_valid_in, .m_addr_in,
      .m_write_in, .m_size_in, .m_wdata_in, .m_done_out, .m_err_out, .m_rdata_out,
      .mem_valid_out, .mem_addr_out, .mem_write_out, .mem_strb_out, .mem_wdata_out,
      .mem_ready_in, .mem_rdata_in, .apb_psel_out, .apb_penable_out, .apb_paddr_out,
      .apb_pwrite_out, .apb_pwdata_out, .apb_pready_in, .apb_prdata_in, .apb_pslverr_in,
      .fld_wr_in, .fld_rd_in, .fld_wdata_in, .fld_hw_set_in, .fld_rdata_out, .fld_trig_out,
      .clk_en_wr_in, .clk_en_wdata_in, .periph_clk_en_out);
   sbm_slave_model MDL (.core_clk_in, .mem_valid_out, .mem_addr_out, .mem_write_out,
      .mem_strb_out, .mem_wdata_out, .mem_ready_in, .mem_rdata_in, .apb_psel_out,
      .apb_penable_out, .apb_paddr_out, .apb_pwrite_out, .apb_pwdata_out, .apb_pready_in,
      .apb_prdata_in, .apb_pslverr_in, .slow_in(slow));
   always #10 core_clk_in = ~core_clk_in;
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic print_verdict;
      $display("failures %0d checked %0d", failures, checked);
      if (failures == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : print_verdict
   // one master transfer, held until done, then released
   task automatic acc(input int m, input logic [31:0] a, input logic w, input logic [1:0] sz,
         input logic [31:0] wd, input logic [31:0] exp, input logic eerr);
      @(posedge core_clk_in) #1;
      m_valid_in[m] = 1'b1;
      m_addr_in[m] = a;
      m_write_in[m] = w;
      m_size_in[m] = sz;
      m_wdata_in[m] = wd;
      for (int i = 0; i < 60; i++) begin
         @(posedge core_clk_in) #1;
         if (m_done_out[m] === 1'b1)
            break;
      end
      chk("done", 32'h1, {31'h0, m_done_out[m]});
      chk("err", {31'h0, eerr}, {31'h0, m_err_out[m]});
      if (!w && !eerr)
         chk("rdata", exp, m_rdata_out[m]);
      order.push_back(m);
      @(posedge core_clk_in) #1;
      m_valid_in[m] = 1'b0;
   endtask : acc
   task automatic fwr(input logic [8:0] d);
      @(posedge core_clk_in) #1;
      fld_wr_in = 1'b1;
      fld_wdata_in = d;
      @(posedge core_clk_in) #1;
      fld_wr_in = 1'b0;
      chk("trig", 32'h80, {23'h0, fld_trig_out});
   endtask : fwr
   task automatic frd(input logic [8:0] e);
      @(posedge core_clk_in) #1;
      fld_rd_in = 1'b1;
      @(posedge core_clk_in) #1;
      fld_rd_in = 1'b0;
      chk("fields", {23'h0, e}, {23'h0, fld_rdata_out});
   endtask : frd
   task automatic t_fields;
      @(posedge core_clk_in) #1;
      fld_hw_set_in = 9'h03a;
      @(posedge core_clk_in) #1;
      fld_hw_set_in = 9'h002;
      frd(9'h03a);
      frd(9'h01a);
      fwr(9'h1df);
      frd(9'h153);
      fwr(9'h000);
      frd(9'h142);
      fld_hw_set_in = 9'h000;
      fwr(9'h102);
      frd(9'h040);
   endtask : t_fields
   task automatic t_sram;
      acc(0, 32'h2000_0004, 1'b1, W, 32'h1122_3344, 32'h0, 1'b0);
      acc(0, 32'h2000_0006, 1'b1, B, 32'h005a_0000, 32'h0, 1'b0);
      acc(1, 32'h2000_0004, 1'b1, H, 32'h0000_beef, 32'h0, 1'b0);
      acc(2, 32'h2000_0004, 1'b0, W, 32'h0, 32'h115a_beef, 1'b0);
   endtask : t_sram
   task automatic t_reserved;
      for (int r = 4; r < 8; r++)
         acc(0, {r[2:0], 29'h40}, 1'b0, W, 32'h0, 32'h0, 1'b1);
   endtask : t_reserved
   task automatic t_apb;
      @(posedge core_clk_in) #1;
      clk_en_wr_in = 1'b1;
      clk_en_wdata_in = 32'h0000_0007;
      @(posedge core_clk_in) #1;
      clk_en_wr_in = 1'b0;
      chk("clk_en", 32'h0000_0007, periph_clk_en_out);
      slow = 2'h2;
      acc(0, 32'h4000_0001, 1'b1, B, 32'h0000_ab00, 32'h0, 1'b0);
      acc(0, 32'h4000_0000, 1'b0, W, 32'h0, 32'habab_abab, 1'b0);
      acc(0, 32'h4000_0002, 1'b1, H, 32'h1234_0000, 32'h0, 1'b0);
      acc(0, 32'h4000_0000, 1'b0, W, 32'h0, 32'h1234_1234, 1'b0);
      acc(0, 32'h4000_00fc, 1'b0, W, 32'h0, 32'h0, 1'b1);
   endtask : t_apb
   task automatic t_masters;
      for (int m = 0; m < 4; m++) begin
         acc(m, {m[2:0], 29'h10}, 1'b1, W, 32'hc0de_0000 + m, 32'h0, 1'b0);
         acc(m, {m[2:0], 29'h10}, 1'b0, W, 32'h0, 32'hc0de_0000 + m, 1'b0);
      end
   endtask : t_masters
   task automatic t_rr;
      slow = 2'h3;
      order.delete();
      fork
         begin
            acc(0, 32'h2000_0020, 1'b1, W, 32'h1, 32'h0, 1'b0);
            acc(0, 32'h2000_0020, 1'b0, W, 32'h0, 32'h1, 1'b0);
         end
         begin
            acc(1, 32'h2000_0024, 1'b1, W, 32'h2, 32'h0, 1'b0);
            acc(1, 32'h2000_0024, 1'b0, W, 32'h0, 32'h2, 1'b0);
         end
         begin
            acc(2, 32'h2000_0028, 1'b1, W, 32'h3, 32'h0, 1'b0);
            acc(2, 32'h2000_0028, 1'b0, W, 32'h0, 32'h3, 1'b0);
         end
      join
      for (int i = 1; i < 6; i++)
         chk("turn", 32'h1, {31'h0, order[i] != order[i-1]});
      for (int i = 2; i < 6; i++)
         chk("rotation", 32'h1, {31'h0, order[i] != order[i-2]});
   endtask : t_rr
   always @(posedge core_clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         print_verdict();
      end
   end
   initial begin
      repeat (8) @(posedge core_clk_in);
      #1 rstn_in = 1'b1;
      chk("clk_en", 32'h0000_0003, periph_clk_en_out);
      t_fields();
      t_sram();
      t_reserved();
      t_apb();
      t_masters();
      t_rr();
      print_verdict();
   end
endmodule : system_bus_matrix_apb_bridge_tb_top
